/* shared/ptgen_pkg.sv */
// Purpose: shared constants and types of the fifo pattern test generator
// Assumes: 128-bit fifo words, 32-bit ahb-lite register bus
// Notes:   register offsets are byte addresses on the bus
package ptgen_pkg;
   // data path geometry
   localparam int unsigned DATA_W      = 128;
   localparam int unsigned DW_W        = 32;
   localparam int unsigned DW_PER_WORD = 4;
   localparam int unsigned ADDR_W      = 48;
   localparam int unsigned INC_W       = 53;
   localparam int unsigned BLK_WORD_W  = 5;
   localparam logic [4:0]  BLK_LAST_WORD = 5'h1f;    // 32 words of 16 bytes make 512 bytes
   localparam logic [52:0] INC_STEP      = 53'h4;    // four dwords per word
   localparam logic [6:0]  INC_DW_LOW    = 7'h00;    // dword index inside a block at block start

   // register map
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_END_SIZE   = 8'h04;
   localparam logic [7:0] REG_ADDR_LO    = 8'h08;
   localparam logic [7:0] REG_ADDR_HI    = 8'h0c;
   localparam logic [7:0] REG_STATUS     = 8'h10;
   localparam logic [7:0] REG_COUNT      = 8'h14;
   localparam logic [7:0] REG_INT_STATUS = 8'h18;
   localparam logic [7:0] REG_INT_CLEAR  = 8'h1c;
   localparam logic [7:0] REG_INT_ENABLE = 8'h20;

   // control, status and interrupt register fields
   localparam int unsigned CTRL_START_BIT  = 0;
   localparam int unsigned CTRL_DIR_BIT    = 1;
   localparam int unsigned CTRL_VERIFY_BIT = 2;
   localparam int unsigned CTRL_CLEAR_BIT  = 3;
   localparam int unsigned CTRL_PATT_LSB   = 4;
   localparam int unsigned STAT_BUSY_BIT   = 0;
   localparam int unsigned STAT_FAIL_BIT   = 1;
   localparam int unsigned INT_DONE_BIT    = 0;
   localparam int unsigned INT_FAIL_BIT    = 1;

   // pattern selector codes
   localparam logic [2:0] PATT_ZERO = 3'h0;
   localparam logic [2:0] PATT_ONE  = 3'h1;
   localparam logic [2:0] PATT_INC  = 3'h2;
   localparam logic [2:0] PATT_DEC  = 3'h3;
   localparam logic [2:0] PATT_LFSR = 3'h4;

   // values after reset
   localparam logic [31:0] END_SIZE_RST = 32'h0000_0000;
   localparam logic [47:0] ADDR_RST     = 48'h0000_0000_0000;
   localparam logic [2:0]  PATT_RST     = 3'h0;
   localparam logic [1:0]  INT_RST      = 2'h0;
   localparam logic [31:0] LFSR_RST     = 32'h0000_0001;
   localparam logic [31:0] LFSR_NONZERO = 32'h0000_0001;

   typedef enum logic [1:0] {
      PTGEN_IDLE,
      PTGEN_WRITE,
      PTGEN_READ
   } ptgen_mode_t;

   // write side of the input fifo
   typedef struct packed {
      logic         en;
      logic [127:0] data;
   } ptgen_wr_t;

   // read side of the output fifo
   typedef struct packed {
      logic         empty;
      logic [127:0] data;
   } ptgen_rd_t;
endpackage : ptgen_pkg

/* rtl/ptgen_lfsr4.sv */
// Purpose: look-ahead lfsr giving four successive 32-bit values per clock
// Assumes: load and advance never asserted together
// Notes:   seed is forced odd so the register never locks at zero
`timescale 1ns/1ps
module ptgen_lfsr4 (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         load,
   input  wire logic [31:0]  seed,
   input  wire logic         advance,
   output logic      [127:0] word
);
   typedef struct packed {
      logic [127:0] q;
   } ptgen_lfsr_t;

   ptgen_lfsr_t s;
   ptgen_lfsr_t next_s;
   logic [31:0] chain [0:4];

   // one step of x^31 + x^21 + x + 1
   function automatic logic [31:0] ptgen_step(input logic [31:0] v);
      ptgen_step = {v[30:0], v[30] ^ v[20] ^ v[0]};
   endfunction : ptgen_step

   // chain starts at the seed on load, else at the newest value held
   assign chain[0] = load ? (seed | ptgen_pkg::LFSR_NONZERO) : s.q[127:96];

   // four unrolled steps in one cycle
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_step
         assign chain[i+1] = ptgen_step(chain[i]);
      end
   endgenerate

   always_comb begin
      next_s = s;
      if (load || advance) begin
         next_s.q = {chain[4], chain[3], chain[2], chain[1]};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s.q <= {4{ptgen_pkg::LFSR_RST}};
      end else begin
         s <= next_s;
      end
   end

   assign word = s.q;

   chk_lfsr_lookahead: assert property (@(posedge hclk) disable iff (!hresetn)
      advance |=> (s.q[31:0] == ptgen_step($past(s.q[127:96])))
              && (s.q[127:96] == ptgen_step(ptgen_step(ptgen_step(s.q[31:0])))))
      else $error("lfsr look-ahead chain broken");
endmodule : ptgen_lfsr4

/* rtl/ptgen_top.sv */
// Purpose: fifo pattern generator and checker with ahb-lite registers
// Assumes: output fifo gives read data one cycle after its read enable
// Notes:   one clock domain; fifo flags are same-clock logic
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - almost full drops write enable, pauses generation
// - read enable high whenever output fifo nonempty during a read run
// - stop enables once word count equals end
// - five patterns; zero and one fixed
// - increment dwords come from 53-bit counter
// - decrement is inverted increment data
// - lfsr polynomial x^31 + x^21 + x + 1
// - look-ahead lfsr gives four values per cycle
// - 64-bit header in dwords 0 and 1
// - block address loads, increments per block
// - size, direction, verify, pattern held in registers
// - same sequence writes and checks read data
// - mismatch with verify enabled sets fail flag
// - start pulse, write active one cycle later
// - all logic shares the user clock
module ptgen_top (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic      [31:0]          hrdata,
   input  wire logic                 in_fifo_almost_full,
   output ptgen_pkg::ptgen_wr_t      in_fifo_write,
   input  wire ptgen_pkg::ptgen_rd_t out_fifo,
   output logic                      out_fifo_read_en,
   output logic                      irq
);
   typedef struct packed {
      ptgen_pkg::ptgen_mode_t mode;
      logic                   start_pulse;
      logic                   dir_read;
      logic                   verify_en;
      logic [2:0]             patt;
      logic [31:0]            end_size;
      logic [47:0]            addr_init;
      logic [31:0]            word_count;
      logic [4:0]             blk_word;
      logic [47:0]            blk_addr;
      logic [52:0]            inc_cnt;
      logic                   wr_en;
      logic [127:0]           wr_data;
      logic                   rd_pend;
      logic [127:0]           expect_data;
      logic                   fail;
      logic [1:0]             int_status;
      logic [1:0]             int_enable;
      logic [31:0]            rdata;
      logic                   bus_wr;
      logic [7:0]             bus_addr;
   } ptgen_state_t;

   ptgen_state_t s;
   ptgen_state_t next_s;

   logic         bus_take;
   logic         issue_wr;
   logic         issue;
   logic         use_header;
   logic [31:0]  rd_mux;
   logic [127:0] pattern_word;
   logic [127:0] lfsr_word;
   logic [31:0]  inc_dw [0:3];

   // ahb-lite address phase: only whole-word nonseq and seq transfers are taken, burst beats included
   assign bus_take  = hsel && hready && htrans[1] && (hsize == 3'h2);
   assign hreadyout = 1'b1;   // zero wait states, every register answers at once
   assign hresp     = 1'b0;
   assign hrdata    = s.rdata;

   // write enable needs an active run, room in the fifo and words left
   assign issue_wr = (s.mode == ptgen_pkg::PTGEN_WRITE) && !in_fifo_almost_full
                     && (s.word_count != s.end_size);
   // read enable follows the empty flag, but never past the end size
   assign out_fifo_read_en = (s.mode == ptgen_pkg::PTGEN_READ) && !out_fifo.empty
                             && (s.word_count != s.end_size);
   assign issue = issue_wr || out_fifo_read_en;

   // header only for the increment, decrement and lfsr patterns, in the first word of a block
   assign use_header = (s.blk_word == 5'h00) && ((s.patt == ptgen_pkg::PATT_INC)
                       || (s.patt == ptgen_pkg::PATT_DEC) || (s.patt == ptgen_pkg::PATT_LFSR));

   // lfsr advances once per word moved, in either direction
   ptgen_lfsr4 u_lfsr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .load    (s.start_pulse),
      .seed    (s.addr_init[31:0]),
      .advance (issue),
      .word    (lfsr_word)
   );

   // per-dword pattern selection
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_dw
         assign inc_dw[i] = s.inc_cnt[31:0] + 32'(i);
         always_comb begin
            unique case (s.patt)
               ptgen_pkg::PATT_ZERO : pattern_word[i*32 +: 32] = 32'h0000_0000;
               ptgen_pkg::PATT_ONE  : pattern_word[i*32 +: 32] = 32'hffff_ffff;
               ptgen_pkg::PATT_INC  : pattern_word[i*32 +: 32] = inc_dw[i];
               ptgen_pkg::PATT_DEC  : pattern_word[i*32 +: 32] = ~inc_dw[i];
               ptgen_pkg::PATT_LFSR : pattern_word[i*32 +: 32] = lfsr_word[i*32 +: 32];
               default              : pattern_word[i*32 +: 32] = 32'h0000_0000;
            endcase
            if (use_header && (i == 0)) begin
               pattern_word[i*32 +: 32] = s.blk_addr[31:0];
            end
            if (use_header && (i == 1)) begin
               pattern_word[i*32 +: 32] = {16'h0000, s.blk_addr[47:32]};
            end
         end
      end
   endgenerate

   // register read view, unmapped offsets read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         ptgen_pkg::REG_CTRL : begin
            rd_mux[ptgen_pkg::CTRL_DIR_BIT]                 = s.dir_read;
            rd_mux[ptgen_pkg::CTRL_VERIFY_BIT]              = s.verify_en;
            rd_mux[ptgen_pkg::CTRL_PATT_LSB +: 3]           = s.patt;
         end
         ptgen_pkg::REG_END_SIZE   : rd_mux = s.end_size;
         ptgen_pkg::REG_ADDR_LO    : rd_mux = s.addr_init[31:0];
         ptgen_pkg::REG_ADDR_HI    : rd_mux[15:0] = s.addr_init[47:32];
         ptgen_pkg::REG_STATUS : begin
            rd_mux[ptgen_pkg::STAT_BUSY_BIT] = (s.mode != ptgen_pkg::PTGEN_IDLE) || s.start_pulse;
            rd_mux[ptgen_pkg::STAT_FAIL_BIT] = s.fail;
         end
         ptgen_pkg::REG_COUNT      : rd_mux = s.word_count;
         ptgen_pkg::REG_INT_STATUS : rd_mux[1:0] = s.int_status;
         ptgen_pkg::REG_INT_ENABLE : rd_mux[1:0] = s.int_enable;
         default                   : rd_mux = 32'h0000_0000;
      endcase
   end

   // all next-state logic: bus, run control, counters, checker, interrupts
   always_comb begin
      logic       clear_req;
      logic       done_ev;
      logic       fail_ev;
      logic [1:0] int_clr;
      clear_req = 1'b0;
      done_ev   = 1'b0;
      fail_ev   = 1'b0;
      int_clr   = 2'h0;
      next_s             = s;
      next_s.start_pulse = 1'b0;
      next_s.wr_en       = 1'b0;
      next_s.rd_pend     = 1'b0;
      next_s.bus_wr      = 1'b0;

      // address phase capture; read data registered for the data phase
      if (bus_take) begin
         next_s.bus_wr   = hwrite;
         next_s.bus_addr = haddr[7:0];
         if (!hwrite) begin
            next_s.rdata = rd_mux;
         end
      end

      // data phase of a write; ctrl frozen while a run is busy (start pulse included), size and address only while the run is active
      if (s.bus_wr) begin
         unique case (s.bus_addr)
            ptgen_pkg::REG_CTRL : begin
               clear_req = hwdata[ptgen_pkg::CTRL_CLEAR_BIT];
               if ((s.mode == ptgen_pkg::PTGEN_IDLE) && !s.start_pulse) begin
                  next_s.dir_read    = hwdata[ptgen_pkg::CTRL_DIR_BIT];
                  next_s.verify_en   = hwdata[ptgen_pkg::CTRL_VERIFY_BIT];
                  next_s.patt        = hwdata[ptgen_pkg::CTRL_PATT_LSB +: 3];
                  next_s.start_pulse = hwdata[ptgen_pkg::CTRL_START_BIT] && !clear_req;
               end
            end
            ptgen_pkg::REG_END_SIZE : begin
               if (s.mode == ptgen_pkg::PTGEN_IDLE) begin
                  next_s.end_size = hwdata;
               end
            end
            ptgen_pkg::REG_ADDR_LO : begin
               if (s.mode == ptgen_pkg::PTGEN_IDLE) begin
                  next_s.addr_init[31:0] = hwdata;
               end
            end
            ptgen_pkg::REG_ADDR_HI : begin
               if (s.mode == ptgen_pkg::PTGEN_IDLE) begin
                  next_s.addr_init[47:32] = hwdata[15:0];
               end
            end
            ptgen_pkg::REG_INT_CLEAR  : int_clr = hwdata[1:0];
            ptgen_pkg::REG_INT_ENABLE : next_s.int_enable = hwdata[1:0];
            default : ;
         endcase
      end

      // start pulse loads counters; the active flag rises one cycle later
      if (s.start_pulse) begin
         next_s.mode       = s.dir_read ? ptgen_pkg::PTGEN_READ : ptgen_pkg::PTGEN_WRITE;
         next_s.word_count = 32'h0000_0000;
         next_s.blk_word   = 5'h00;
         next_s.blk_addr   = s.addr_init;
         next_s.inc_cnt    = {s.addr_init[45:0], ptgen_pkg::INC_DW_LOW};
         next_s.fail       = 1'b0;
      end

      // run control
      unique case (s.mode)
         ptgen_pkg::PTGEN_IDLE : ;
         ptgen_pkg::PTGEN_WRITE : begin
            if (issue_wr) begin
               next_s.wr_en   = 1'b1;
               next_s.wr_data = pattern_word;
            end else if (s.word_count == s.end_size) begin
               next_s.mode = ptgen_pkg::PTGEN_IDLE;
               done_ev     = 1'b1;
            end
         end
         ptgen_pkg::PTGEN_READ : begin
            if (out_fifo_read_en) begin
               next_s.rd_pend     = 1'b1;
               next_s.expect_data = pattern_word;
            end else if ((s.word_count == s.end_size) && !s.rd_pend) begin
               next_s.mode = ptgen_pkg::PTGEN_IDLE;
               done_ev     = 1'b1;
            end
         end
      endcase

      // counters advance with each word moved
      if (issue) begin
         next_s.word_count = s.word_count + 32'h0000_0001;
         next_s.blk_word   = s.blk_word + 5'h01;
         next_s.inc_cnt    = s.inc_cnt + ptgen_pkg::INC_STEP;
         if (s.blk_word == ptgen_pkg::BLK_LAST_WORD) begin
            next_s.blk_addr = s.blk_addr + 48'h0000_0000_0001;
         end
      end

      // checker: read data arrives the cycle after the read enable
      if (s.rd_pend && s.verify_en && (out_fifo.data != s.expect_data)) begin
         fail_ev = 1'b1;
      end

      // soft clear stops the run and empties counters
      if (clear_req) begin
         next_s.mode       = ptgen_pkg::PTGEN_IDLE;
         next_s.word_count = 32'h0000_0000;
         next_s.blk_word   = 5'h00;
         next_s.blk_addr   = s.addr_init;
         next_s.inc_cnt    = {s.addr_init[45:0], ptgen_pkg::INC_DW_LOW};
         next_s.rd_pend    = 1'b0;
         next_s.fail       = 1'b0;
      end

      // sticky flags: a new event wins over a clear in the same cycle
      next_s.fail = next_s.fail || fail_ev;
      next_s.int_status = (s.int_status & ~int_clr)
                          | {fail_ev, 1'b0} | {1'b0, done_ev};
   end

   // single state register; async reset only loads constants
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s             <= '0;
         s.mode        <= ptgen_pkg::PTGEN_IDLE;
         s.patt        <= ptgen_pkg::PATT_RST;
         s.end_size    <= ptgen_pkg::END_SIZE_RST;
         s.addr_init   <= ptgen_pkg::ADDR_RST;
         s.blk_addr    <= ptgen_pkg::ADDR_RST;
         s.int_status  <= ptgen_pkg::INT_RST;
         s.int_enable  <= ptgen_pkg::INT_RST;
      end else begin
         s <= next_s;
      end
   end

   // outputs
   assign in_fifo_write.en   = s.wr_en;
   assign in_fifo_write.data = s.wr_data;
   assign irq                = |(s.int_status & s.int_enable);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_afull_pause: assert property (in_fifo_almost_full |=> !in_fifo_write.en)
      else $error("write enable high after almost full");
   chk_read_follow: assert property ((s.mode == ptgen_pkg::PTGEN_READ) && !out_fifo.empty
                                     && (s.word_count != s.end_size) |-> out_fifo_read_en)
      else $error("read enable low with data present");
   chk_count_limit: assert property ((s.word_count == s.end_size) && (s.mode != ptgen_pkg::PTGEN_IDLE)
                                     |=> !in_fifo_write.en && !$past(out_fifo_read_en))
      else $error("transfer past end size");
   chk_fixed_ones: assert property (in_fifo_write.en && (s.patt == ptgen_pkg::PATT_ONE)
                                    |-> (in_fifo_write.data == {4{32'hffff_ffff}}))
      else $error("all-one pattern not fixed");
   chk_dec_invert: assert property (issue_wr && (s.patt == ptgen_pkg::PATT_DEC) && !use_header
                                    |=> in_fifo_write.data[31:0] == ~$past(s.inc_cnt[31:0]))
      else $error("decrement word not inverted increment");
   chk_header_fields: assert property (issue_wr && use_header
                                       |=> (in_fifo_write.data[63:32] == {16'h0000, $past(s.blk_addr[47:32])})
                                       && (in_fifo_write.data[31:0] == $past(s.blk_addr[31:0])))
      else $error("block header wrong");
   chk_block_step: assert property (issue && (s.blk_word == ptgen_pkg::BLK_LAST_WORD)
                                    |=> (s.blk_addr == $past(s.blk_addr) + 48'h0000_0000_0001) && (s.blk_word == 5'h00))
      else $error("block address not stepped");
   chk_start_active: assert property (s.start_pulse && !s.dir_read
                                      |-> (s.mode == ptgen_pkg::PTGEN_IDLE) ##1 (s.mode == ptgen_pkg::PTGEN_WRITE))
      else $error("write active not one cycle after start");
   chk_fail_set: assert property (s.rd_pend && s.verify_en && (out_fifo.data != s.expect_data)
                                  |=> s.fail && s.int_status[ptgen_pkg::INT_FAIL_BIT])
      else $error("mismatch did not set fail");
   chk_soft_clear: assert property (s.bus_wr && (s.bus_addr == ptgen_pkg::REG_CTRL)
                                    && hwdata[ptgen_pkg::CTRL_CLEAR_BIT] && !(s.rd_pend && s.verify_en)
                                    |=> !s.fail && (s.word_count == 32'h0000_0000) && (s.mode == ptgen_pkg::PTGEN_IDLE))
      else $error("soft clear incomplete");
   chk_fixed_zeros: assert property (in_fifo_write.en && (s.patt == ptgen_pkg::PATT_ZERO)
                                     |-> (in_fifo_write.data == {4{32'h0000_0000}}))
      else $error("all-zero pattern not fixed");
   chk_inc_step: assert property (issue && !(s.bus_wr && (s.bus_addr == ptgen_pkg::REG_CTRL)
                                  && hwdata[ptgen_pkg::CTRL_CLEAR_BIT])
                                  |=> (s.inc_cnt == $past(s.inc_cnt) + ptgen_pkg::INC_STEP))
      else $error("increment counter did not step");
   chk_write_gated: assert property (in_fifo_write.en |-> $past(s.mode == ptgen_pkg::PTGEN_WRITE))
      else $error("write enable outside a write run");
   chk_done_write: assert property ((s.mode == ptgen_pkg::PTGEN_WRITE) && (s.word_count == s.end_size)
                                    |=> (s.mode == ptgen_pkg::PTGEN_IDLE) && s.int_status[ptgen_pkg::INT_DONE_BIT])
      else $error("write run did not finish");
endmodule : ptgen_top

/* tb/ptgen_fifo_model.sv */
// Purpose: far side of both data fifos of the generator
// Assumes: one-cycle read latency, shared hclk
// Notes:   stale read data is inverted each cycle so it never passes
`timescale 1ns/1ps
module ptgen_fifo_model #(parameter int DEPTH = 512) (
   input  wire logic            hclk,
   input  wire logic            stall,
   input  wire logic            slow,
   input  wire logic            read_en,
   output logic                 almost_full,
   output ptgen_pkg::ptgen_rd_t rd
);
   logic [127:0] q[$];
   logic [1:0]   tick = 2'h0;
   initial begin
      almost_full = 1'b0;
      rd = '{empty: 1'b1, data: 128'h0};
   end
   // stalls come in bursts of three, slow mode hides data every other cycle
   always @(posedge hclk) begin
      tick <= tick + 2'h1;
      almost_full <= stall && tick != 2'h0;
      rd.data <= read_en ? q.pop_front() : ~rd.data;
      rd.empty <= q.size() == 0 || (slow && tick[0]);
   end
   function automatic void push(input logic [127:0] w);
      if (q.size() < DEPTH) q.push_back(w);
   endfunction : push
endmodule : ptgen_fifo_model

/* tb/fifo_pattern_test_generator_test.sv */
// Purpose: self-checking bench of the pattern generator
// Assumes: zero-wait bus slave, model fifos on hclk
// Notes:   expected words are rebuilt here, never read from the design
`timescale 1ns/1ps
module fifo_pattern_test_generator_test;
   logic                 hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]          haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
   logic [1:0]           htrans = 2'h0;
   logic [2:0]           hsize = 3'h2, patt;
   logic                 hreadyout, hresp, rden, irq, afull, af_q = 1'b0;
   logic                 stall = 1'b0, slow = 1'b0, ien;
   ptgen_pkg::ptgen_wr_t inw;
   ptgen_pkg::ptgen_rd_t ofifo;
   logic [47:0]          base;
   logic [31:0]          lf;
   int                   wk, fail_count = 0, check_count = 0;

   // 20 mhz clock
   always #25 hclk = ~hclk;

   ptgen_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .in_fifo_almost_full(afull), .in_fifo_write(inw),
      .out_fifo(ofifo), .out_fifo_read_en(rden), .irq(irq));
   ptgen_fifo_model u_far (.hclk(hclk), .stall(stall), .slow(slow), .read_en(rden),
      .almost_full(afull), .rd(ofifo));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one single-word transfer; hready is the slave's own hreadyout
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
      r = hrdata;
      if (n >= 100) begin fail_count++; print_verdict(); end
   endtask : bus

   // next word of the sequence, advancing word index and lfsr state
   function automatic logic [127:0] next_exp();
      logic [127:0] w;
      logic [52:0]  c;
      logic [47:0]  b;
      c = {base[45:0], 7'h00} + 53'(wk) * 53'h4;
      b = base + 48'(wk / 32);
      for (int i = 0; i < 4; i++) begin
         lf = {lf[30:0], lf[30] ^ lf[20] ^ lf[0]};
         w[32*i +: 32] = patt == ptgen_pkg::PATT_ONE ? 32'hffff_ffff :
            patt == ptgen_pkg::PATT_INC ? c[31:0] + 32'(i) : patt == ptgen_pkg::PATT_DEC ?
            ~(c[31:0] + 32'(i)) : patt == ptgen_pkg::PATT_LFSR ? lf : 32'h0000_0000;
      end
      if (wk % 32 == 0 && patt >= ptgen_pkg::PATT_INC && patt <= ptgen_pkg::PATT_LFSR)
         w[63:0] = {16'h0000, b[47:32], b[31:0]};
      wk++;
      return w;
   endfunction : next_exp

   // programs one run, waits for idle, then checks count, fail and interrupt
   task automatic run(input logic [2:0] p, input logic dir, input logic [31:0] n, input logic bad, input logic vfy);
      logic [31:0] r;
      int          k;
      patt = p;
      wk = 0;
      lf = base[31:0] | 32'h0000_0001;
      for (k = 0; dir && k < n + 2; k++) u_far.push(next_exp() ^ 128'(bad && k == 5));
      wk = 0;
      lf = base[31:0] | 32'h0000_0001;
      bus(1'b1, ptgen_pkg::REG_END_SIZE, n, r);
      bus(1'b1, ptgen_pkg::REG_ADDR_LO, base[31:0], r);
      bus(1'b1, ptgen_pkg::REG_ADDR_HI, {16'h0000, base[47:32]}, r);
      bus(1'b1, ptgen_pkg::REG_CTRL, {25'h0, p, 1'b0, vfy, dir, 1'b1}, r);
      repeat (3) @(posedge hclk);
      k = 0;
      do begin bus(1'b0, ptgen_pkg::REG_STATUS, 32'h0, r); k++; end while (r[0] !== 1'b0 && k < 3000);
      if (k >= 3000) begin fail_count++; print_verdict(); end
      check(r[1], bad && vfy);
      bus(1'b0, ptgen_pkg::REG_COUNT, 32'h0, r);
      check(r, n);
      if (!dir) check(wk, n);
      bus(1'b0, ptgen_pkg::REG_INT_STATUS, 32'h0, r);
      check(r[1:0], {bad && vfy, 1'b1});
      check(irq, ien);
      bus(1'b1, ptgen_pkg::REG_INT_CLEAR, 32'h0000_0003, r);
      @(negedge hclk);
      check(irq, 1'b0);
      @(posedge hclk);
      $display("run pattern %0d dir %0d done", p, dir);
   endtask : run

   // stream monitor at mid cycle, where registered outputs have settled
   always @(negedge hclk) begin
      if (inw.en === 1'b1) check(inw.data, next_exp());
      if (af_q && inw.en === 1'b1) check(1'b1, 1'b0);
      af_q = afull;
   end

   // main sequence: reset values, every write pattern, failing and clean reads
   initial begin
      logic [31:0] r;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(irq, 1'b0);
      check({hresp, hreadyout}, 2'h1);
      bus(1'b0, ptgen_pkg::REG_END_SIZE, 32'h0, r);
      check(r, ptgen_pkg::END_SIZE_RST);
      bus(1'b0, 8'hfc, 32'h0, r);
      check(r, 32'h0000_0000);
      ien = 1'b1;
      bus(1'b1, ptgen_pkg::REG_INT_ENABLE, 32'h0000_0003, r);
      base = 48'h0001_2345_67e0;
      for (int p = 0; p < 5; p++) begin
         stall <= p[0];
         run(3'(p), 1'b0, 32'h0000_0022, 1'b0, 1'b1);
      end
      stall <= 1'b0;
      slow <= 1'b1;
      base = 48'h0000_0000_0003;
      run(ptgen_pkg::PATT_INC, 1'b1, 32'h0000_000c, 1'b1, 1'b1);
      check(u_far.q.size(), 2);
      u_far.q.delete();
      bus(1'b1, ptgen_pkg::REG_CTRL, 32'h0000_0008, r);
      @(posedge hclk);
      bus(1'b0, ptgen_pkg::REG_STATUS, 32'h0, r);
      check(r[1], 1'b0);
      ien = 1'b0;
      bus(1'b1, ptgen_pkg::REG_INT_ENABLE, 32'h0000_0000, r);
      run(ptgen_pkg::PATT_LFSR, 1'b1, 32'h0000_0028, 1'b0, 1'b1);
      // corrupted read with verify off must not flag a failure
      u_far.q.delete();
      run(ptgen_pkg::PATT_DEC, 1'b1, 32'h0000_000c, 1'b1, 1'b0);
      print_verdict();
   end
endmodule : fifo_pattern_test_generator_test
